// File: design/gear_scaler.sv
// Electronic gear scaler: program travel to servo pulses with exact remainder carry
`timescale 1ns/10ps
module gear_scaler
(
   input wire logic CLK,
   input wire logic RSTN,
   input wire logic [31:0] PULSES_PER_ROTATION,
   input wire logic [31:0] TRAVEL_PER_ROTATION,
   input wire logic [15:0] BACKLASH_AMOUNT,
   input wire logic BACKLASH_EXPANDED,
   input wire logic CMD_VALID,
   input wire logic [31:0] CMD_TRAVEL,
   input wire logic HOME_DONE,
   input wire logic CURVAL_CHANGE_DONE,
   input wire logic SPEED_SWITCH_START,
   input wire logic FEED_VALUE_UPDATE,
   input wire logic FIXED_PITCH_START,
   output logic CMD_READY,
   output logic CMD_REJECT,
   output logic PULSE_VALID,
   output logic [31:0] PULSE_OUT,
   output logic [32:0] REMAINDER,
   output logic RATIO_INVALID,
   output logic BACKLASH_INVALID
);
   // Sequencer state, residue and registered outputs
   gear_pkg::gear_state_t state_r, state_nxt;
   logic [32:0] rem_r, rem_nxt;
   logic [31:0] pulse_r, pulse_nxt;
   logic pvalid_r, pvalid_nxt;
   logic reject_r, reject_nxt;
   logic ready_r, ready_nxt;
   logic neg_r, neg_nxt;
   logic clr_pend_r, clr_pend_nxt;
   logic ratio_bad_r, ratio_bad_nxt;
   logic bl_bad_r, bl_bad_nxt;
   // Divider handshake and conversion arithmetic
   logic clear_evt;
   logic div_start;
   logic div_done;
   logic [63:0] div_q;
   logic [31:0] div_r;
   logic [65:0] num;
   logic [63:0] mag;
   logic [63:0] q_signed;
   logic [32:0] r_signed;
   logic [65:0] mag_full;
   logic [65:0] q_full;
   logic [65:0] r_full;

   // Two's complement negate, used on dividend, quotient and residue
   function automatic logic [65:0] neg66(input logic [65:0] v, input logic n);
      neg66 = n ? (66'h0 - v) : v;
   endfunction

   // --------------------------------------------------------------
   // Configuration checks
   // --------------------------------------------------------------
   always_comb
   begin
      // Flags lag the inputs by one cycle; hold the gear steady while converting
      // Products are formed at 48 bits so that neither side can overflow
      // Ratio below 0.001 or above 20000 is refused
      ratio_bad_nxt = (PULSES_PER_ROTATION == 32'h0) || (TRAVEL_PER_ROTATION == 32'h0)
         || (48'(PULSES_PER_ROTATION) * 48'(gear_pkg::RATIO_MIN_DEN)
             < 48'(TRAVEL_PER_ROTATION))
         || (48'(PULSES_PER_ROTATION)
             > 48'(TRAVEL_PER_ROTATION) * 48'(gear_pkg::RATIO_MAX_NUM));
      // Backlash in pulses is amount * pulses / travel, compared without division
      bl_bad_nxt = !BACKLASH_EXPANDED
         && (48'(BACKLASH_AMOUNT) * 48'(PULSES_PER_ROTATION)
             > 48'(TRAVEL_PER_ROTATION) * 48'(gear_pkg::BACKLASH_MAX_PLS));
   end

   // --------------------------------------------------------------
   // Conversion arithmetic
   // --------------------------------------------------------------
   always_comb
   begin
      // Travel in least command units (0.1 um for mm axes) times pulses per turn
      num = {{34{CMD_TRAVEL[31]}}, CMD_TRAVEL} * {34'h0, PULSES_PER_ROTATION}
         + {{33{rem_r[32]}}, rem_r};
      // The divider works on magnitudes only; the sign comes back afterwards
      mag_full = neg66(num, num[65]);
      mag = mag_full[63:0];
      // Negating the quotient truncates toward zero, so the residue keeps the sign
      q_full = neg66({2'b00, div_q}, neg_r);
      q_signed = q_full[63:0];
      r_full = neg66({34'h0, div_r}, neg_r);
      r_signed = r_full[32:0];
   end

   assign clear_evt = HOME_DONE || CURVAL_CHANGE_DONE || FIXED_PITCH_START
      || (SPEED_SWITCH_START && !FEED_VALUE_UPDATE);
   // Ready gates the start too, so nothing is taken in the first cycle after reset
   assign div_start = (state_r == gear_pkg::ST_IDLE) && ready_r && CMD_VALID && !ratio_bad_r;

   // --------------------------------------------------------------
   // Command sequencing and remainder bookkeeping
   // --------------------------------------------------------------
   always_comb
   begin
      state_nxt = state_r;
      rem_nxt = rem_r;
      pulse_nxt = pulse_r;
      pvalid_nxt = 1'b0;
      reject_nxt = 1'b0;
      neg_nxt = neg_r;
      clr_pend_nxt = clr_pend_r;
      unique case (state_r)
         // Idle: take a command or refuse it
         gear_pkg::ST_IDLE:
         begin
            if (CMD_VALID && ready_r && ratio_bad_r)
            begin
               reject_nxt = 1'b1;
            end
            else if (CMD_VALID && ready_r)
            begin
               neg_nxt = num[65];
               clr_pend_nxt = 1'b0;
               state_nxt = gear_pkg::ST_DIV;
            end
         end
         // Divide: wait for the divider, then publish the result
         gear_pkg::ST_DIV:
         begin
            if (div_done)
            begin
               // Integer part goes out, signed residue carries forward
               pulse_nxt = q_signed[31:0];
               pvalid_nxt = 1'b1;
               rem_nxt = clr_pend_r ? gear_pkg::REM_RESET : r_signed;
               clr_pend_nxt = 1'b0;
               state_nxt = gear_pkg::ST_IDLE;
            end
         end
      endcase
      // Any clear zeroes the residue at once; a conversion in flight, or one
      // starting now, also has its own residue dropped when it finishes
      if (clear_evt)
      begin
         rem_nxt = gear_pkg::REM_RESET;
         if (state_nxt == gear_pkg::ST_DIV)
         begin
            clr_pend_nxt = 1'b1;
         end
      end
      // Ready is registered from the next state, so it matches the state except during reset and in the first cycle after it, when it is low
      ready_nxt = (state_nxt == gear_pkg::ST_IDLE);
   end

   // Register the sequencer and flags
   always_ff @(posedge CLK)
   begin
      if (!RSTN)
      begin
         state_r <= gear_pkg::ST_IDLE;
         rem_r <= gear_pkg::REM_RESET;
         pulse_r <= gear_pkg::PULSE_RESET;
         pvalid_r <= 1'b0;
         reject_r <= 1'b0;
         ready_r <= 1'b0;
         neg_r <= 1'b0;
         clr_pend_r <= 1'b0;
         ratio_bad_r <= 1'b1;
         bl_bad_r <= 1'b0;
      end
      else
      begin
         state_r <= state_nxt;
         rem_r <= rem_nxt;
         pulse_r <= pulse_nxt;
         pvalid_r <= pvalid_nxt;
         reject_r <= reject_nxt;
         ready_r <= ready_nxt;
         neg_r <= neg_nxt;
         clr_pend_r <= clr_pend_nxt;
         ratio_bad_r <= ratio_bad_nxt;
         bl_bad_r <= bl_bad_nxt;
      end
   end

   // --------------------------------------------------------------
   // Divider
   // --------------------------------------------------------------
   // Magnitude division by travel per rotation
   gear_divider u_div
   (
      .CLK(CLK),
      .RSTN(RSTN),
      .start(div_start),
      .dividend(mag),
      .divisor(TRAVEL_PER_ROTATION),
      .done(div_done),
      .quotient(div_q),
      .remainder(div_r)
   );

   // --------------------------------------------------------------
   // Outputs
   // --------------------------------------------------------------
   // Every output comes straight from a register
   assign CMD_READY = ready_r;
   assign CMD_REJECT = reject_r;
   assign PULSE_VALID = pvalid_r;
   assign PULSE_OUT = pulse_r;
   assign REMAINDER = rem_r;
   assign RATIO_INVALID = ratio_bad_r;
   assign BACKLASH_INVALID = bl_bad_r;
endmodule // gear_scaler

// File: design/gear_pkg.sv
// Constants shared by the electronic gear scaler and its divider
package gear_pkg;
   // Gear ratio window: 1/1000 <= pulses / travel <= 20000
   localparam logic [15:0] RATIO_MIN_DEN = 16'h03E8;
   localparam logic [15:0] RATIO_MAX_NUM = 16'h4E20;
   // Backlash pulse ceiling without the expanded range
   localparam logic [15:0] BACKLASH_MAX_PLS = 16'hFFFF;
   // Divider sizing
   localparam int DIVIDEND_W = 64;
   localparam int DIVISOR_W = 32;
   localparam logic [6:0] DIV_STEPS = 7'h40;
   // Reset values
   localparam logic [32:0] REM_RESET = 33'h0_0000_0000;
   localparam logic [31:0] PULSE_RESET = 32'h0000_0000;
   typedef enum logic [0:0]
   {
      ST_IDLE = 1'b0,
      ST_DIV = 1'b1
   } gear_state_t;
endpackage

// File: design/gear_divider.sv
// Sequential unsigned restoring divider, one quotient bit per clock
`timescale 1ns/10ps
module gear_divider
(
   input wire logic CLK,
   input wire logic RSTN,
   input wire logic start,
   input wire logic [63:0] dividend,
   input wire logic [31:0] divisor,
   output logic done,
   output logic [63:0] quotient,
   output logic [31:0] remainder
);
   logic [63:0] q_r, q_nxt;
   logic [32:0] r_r, r_nxt;
   logic [31:0] d_r, d_nxt;
   logic [6:0] cnt_r, cnt_nxt;
   logic busy_r, busy_nxt;
   logic done_r, done_nxt;
   logic [32:0] trial;

   // --------------------------------------------------------------
   // Shift-subtract step
   // --------------------------------------------------------------
   always_comb
   begin
      q_nxt = q_r;
      r_nxt = r_r;
      d_nxt = d_r;
      cnt_nxt = cnt_r;
      busy_nxt = busy_r;
      done_nxt = 1'b0;
      trial = {r_r[31:0], q_r[63]};
      if (start && !busy_r)
      begin
         q_nxt = dividend;
         r_nxt = 33'h0_0000_0000;
         d_nxt = divisor;
         cnt_nxt = gear_pkg::DIV_STEPS;
         busy_nxt = 1'b1;
      end
      else if (busy_r)
      begin
         // Compare the partial remainder against the divisor
         if (trial >= {1'b0, d_r})
         begin
            r_nxt = trial - {1'b0, d_r};
            q_nxt = {q_r[62:0], 1'b1};
         end
         else
         begin
            r_nxt = trial;
            q_nxt = {q_r[62:0], 1'b0};
         end
         cnt_nxt = cnt_r - 7'h01;
         if (cnt_r == 7'h01)
         begin
            busy_nxt = 1'b0;
            done_nxt = 1'b1;
         end
      end
   end

   // Register the divider state
   always_ff @(posedge CLK)
   begin
      if (!RSTN)
      begin
         q_r <= 64'h0;
         r_r <= 33'h0_0000_0000;
         d_r <= 32'h0;
         cnt_r <= 7'h00;
         busy_r <= 1'b0;
         done_r <= 1'b0;
      end
      else
      begin
         q_r <= q_nxt;
         r_r <= r_nxt;
         d_r <= d_nxt;
         cnt_r <= cnt_nxt;
         busy_r <= busy_nxt;
         done_r <= done_nxt;
      end
   end

   assign done = done_r;
   assign quotient = q_r;
   assign remainder = r_r[31:0];
endmodule // gear_divider

// File: tb/gear_scaler_monitor.sv
// Port checker for the gear scaler
`timescale 1ns/10ps
module gear_scaler_monitor
(
   input wire logic CLK,
   input wire logic RSTN,
   input wire logic [31:0] PULSES_PER_ROTATION,
   input wire logic [31:0] TRAVEL_PER_ROTATION,
   input wire logic [15:0] BACKLASH_AMOUNT,
   input wire logic BACKLASH_EXPANDED,
   input wire logic CMD_VALID,
   input wire logic HOME_DONE,
   input wire logic CURVAL_CHANGE_DONE,
   input wire logic SPEED_SWITCH_START,
   input wire logic FEED_VALUE_UPDATE,
   input wire logic FIXED_PITCH_START,
   input wire logic CMD_READY,
   input wire logic CMD_REJECT,
   input wire logic PULSE_VALID,
   input wire logic [32:0] REMAINDER,
   input wire logic RATIO_INVALID,
   input wire logic BACKLASH_INVALID
);
   // Expected flags and clear request from the inputs
   wire logic [63:0] ap = {32'h0, PULSES_PER_ROTATION};
   wire logic [63:0] al = {32'h0, TRAVEL_PER_ROTATION};
   wire logic bad_ratio = ap == 64'h0 || al == 64'h0 || ap * 64'h3E8 < al || ap > al * 64'h4E20;
   wire logic bad_bl = !BACKLASH_EXPANDED && {48'h0, BACKLASH_AMOUNT} * ap > al * 64'hFFFF;
   wire logic clr = HOME_DONE || CURVAL_CHANGE_DONE || FIXED_PITCH_START
      || (SPEED_SWITCH_START && !FEED_VALUE_UPDATE);
   wire logic take = CMD_VALID && CMD_READY;
   default clocking @(posedge CLK); endclocking
   default disable iff (!RSTN);
   a_ratio_flag: assert property ($past(RSTN, 2) |-> RATIO_INVALID == $past(bad_ratio))
      else $error("ratio flag wrong");
   a_backlash_flag: assert property ($past(RSTN, 2) |-> BACKLASH_INVALID == $past(bad_bl))
      else $error("backlash flag wrong");
   a_reject_next: assert property (take && RATIO_INVALID |=> CMD_REJECT)
      else $error("no reject pulse");
   a_result_time: assert property (take && !RATIO_INVALID |-> ##66 PULSE_VALID)
      else $error("result late or missing");
   a_busy_hold: assert property (take && !RATIO_INVALID |=> !CMD_READY [*8])
      else $error("ready during conversion");
   a_valid_once: assert property (PULSE_VALID |=> !PULSE_VALID)
      else $error("result strobe too long");
   a_ready_result: assert property (PULSE_VALID |-> CMD_READY)
      else $error("not ready at result");
   a_clear_rem: assert property (clr && CMD_READY |=> REMAINDER == 33'h0_0000_0000)
      else $error("remainder not cleared");
   a_rem_bound: assert property (PULSE_VALID |->
      (REMAINDER[32] ? -REMAINDER : REMAINDER) < {1'b0, TRAVEL_PER_ROTATION})
      else $error("remainder out of range");
endmodule // gear_scaler_monitor

// File: tb/servo_amp_model.sv
// Servo amplifier stand-in that counts commanded pulses as feedback
`timescale 1ns/10ps
module servo_amp_model
#(
   parameter int amp_encoder_res_numerator = 1,
   parameter int amp_encoder_res_denominator = 1
)
(
   input wire logic CLK,
   input wire logic RSTN,
   input wire logic PULSE_VALID,
   input wire logic [31:0] PULSE_OUT,
   output logic signed [63:0] feedback_r
);
   logic signed [63:0] feedback_nxt;
   // Add each integer pulse batch to the encoder position
   always_comb
      feedback_nxt = PULSE_VALID ? feedback_r + 64'($signed(PULSE_OUT))
         * amp_encoder_res_numerator / amp_encoder_res_denominator : feedback_r;
   always_ff @(posedge CLK)
      feedback_r <= !RSTN ? 64'h0 : feedback_nxt;
endmodule // servo_amp_model

// File: tb/testbench.sv
// Self-checking bench for the gear scaler
`timescale 1ns/10ps
module testbench;
   logic CLK = 1'b0;
   logic RSTN = 1'b0;
   logic [31:0] ap = 32'h0000_4E20;
   logic [31:0] al = 32'h0000_4E20;
   logic [15:0] bl = 16'h0000;
   logic bx = 1'b0;
   logic cv = 1'b0;
   logic [31:0] trv = 32'h0;
   logic [4:0] ev = 5'h00;
   logic rdy, rej, pv, rinv, binv;
   logic [31:0] pout;
   logic [32:0] rem;
   logic signed [63:0] fb;
   logic [4:0] masks [5] = '{5'h01, 5'h02, 5'h04, 5'h08, 5'h18};
   int error_cnt = 0;
   int checked = 0;
   longint rem_e = 0;
   longint pos_e = 0;
   // Recommended backlash ceiling from motor speed, encoder counts and cycle time;
   // the factor 1.2 and the 60000 divisor are both scaled by ten to stay integer
   localparam int MOTOR_RPM = 6000;
   localparam int ENC_RES = 4096;
   localparam int CYCLE_MS = 1;
   localparam int BL_LIMIT = MOTOR_RPM * 12 * ENC_RES * CYCLE_MS / 600000;
   always #5 CLK = ~CLK;
   gear_scaler gear_scaler_i (.CLK(CLK), .RSTN(RSTN), .PULSES_PER_ROTATION(ap),
      .TRAVEL_PER_ROTATION(al), .BACKLASH_AMOUNT(bl), .BACKLASH_EXPANDED(bx),
      .CMD_VALID(cv), .CMD_TRAVEL(trv), .HOME_DONE(ev[0]), .CURVAL_CHANGE_DONE(ev[1]),
      .FIXED_PITCH_START(ev[2]), .SPEED_SWITCH_START(ev[3]), .FEED_VALUE_UPDATE(ev[4]),
      .CMD_READY(rdy), .CMD_REJECT(rej), .PULSE_VALID(pv), .PULSE_OUT(pout),
      .REMAINDER(rem), .RATIO_INVALID(rinv), .BACKLASH_INVALID(binv));
   servo_amp_model servo_amp_model_i (.CLK(CLK), .RSTN(RSTN), .PULSE_VALID(pv),
      .PULSE_OUT(pout), .feedback_r(fb));
   task wrap_up;
      if (error_cnt == 0 && checked > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask
   task chk(input string nm, input logic [63:0] e, input logic [63:0] g);
      checked++;
      if (g !== e)
      begin
         error_cnt++;
         $display("BAD %s exp %0h got %0h", nm, e, g);
      end
   endtask
   task cfg(input logic [31:0] p, l, input logic [15:0] b, input logic x, ri, bi);
      @(posedge CLK);
      ap <= p;
      al <= l;
      bl <= b;
      bx <= x;
      repeat (3) @(posedge CLK);
      @(negedge CLK);
      chk("ratio_flag", 64'(ri), 64'(rinv));
      chk("backlash_flag", 64'(bi), 64'(binv));
   endtask
   task offer(input logic [31:0] t);
      @(posedge CLK);
      cv <= 1'b1;
      trv <= t;
      @(posedge CLK);
      cv <= 1'b0;
   endtask
   task cmd(input logic [31:0] t, input logic mid);
      longint num, q;
      int n;
      num = longint'($signed(t)) * longint'(ap) + rem_e;
      q = num / longint'(al);
      rem_e = mid ? 0 : num - q * longint'(al);
      pos_e += q;
      offer(t);
      // A clear in mid conversion drops this result's residue
      if (mid)
      begin
         repeat (10) @(posedge CLK);
         ev <= 5'h01;
         @(posedge CLK);
         ev <= 5'h00;
      end
      for (n = 0; n < 100 && pv !== 1'b1; n++)
         @(negedge CLK);
      if (n == 100)
      begin
         error_cnt++;
         wrap_up();
      end
      chk("pulses", 64'(q), 64'($signed(pout)));
      chk("remainder", 64'(rem_e), 64'($signed(rem)));
   endtask
   task evt(input logic [4:0] m);
      @(posedge CLK);
      ev <= m;
      @(posedge CLK);
      ev <= 5'h00;
      @(negedge CLK);
      if (m != 5'h18)
         rem_e = 0;
      chk("cleared", 64'(rem_e), 64'($signed(rem)));
   endtask
   // Main sequence
   initial
   begin
      repeat (4) @(posedge CLK);
      @(negedge CLK);
      chk("ready_in_reset", 64'h0, 64'(rdy));
      @(posedge CLK);
      RSTN <= 1'b1;
      cfg(32'h0004_0000, 32'h0003_0D40, 16'h0, 1'b0, 1'b0, 1'b0);
      cmd(32'h0002_E630, 1'b0);
      cmd(32'h0002_E630, 1'b0);
      cmd(32'hFFFD_19D0, 1'b0);
      cfg(32'h3, 32'hA, 16'h0, 1'b0, 1'b0, 1'b0);
      repeat (4) cmd(32'h1, 1'b0);
      for (int i = 0; i < 5; i++)
      begin
         cmd(32'h1, 1'b0);
         evt(masks[i]);
      end
      cmd(32'h7, 1'b1);
      cfg(32'h1, 32'h3E8, 16'h0, 1'b0, 1'b0, 1'b0);
      cfg(32'h1, 32'h3E9, 16'h0, 1'b0, 1'b1, 1'b0);
      cfg(32'h4E20, 32'h1, 16'h0, 1'b0, 1'b0, 1'b0);
      cfg(32'h4E21, 32'h1, 16'h0, 1'b0, 1'b1, 1'b0);
      cfg(32'h0, 32'h5, 16'h0, 1'b0, 1'b1, 1'b0);
      offer(32'h1);
      @(negedge CLK);
      chk("reject", 64'h1, 64'(rej));
      cfg(32'h1, 32'h1, 16'hFFFF, 1'b0, 1'b0, 1'b0);
      cfg(32'h2, 32'h1, 16'h9C40, 1'b0, 1'b0, 1'b1);
      cfg(32'h2, 32'h1, 16'h9C40, 1'b1, 1'b0, 1'b0);
      cfg(32'h1, 32'h1, 16'(BL_LIMIT), 1'b0, 1'b0, 1'b0);
      chk("feedback", 64'(pos_e), 64'(fb));
      wrap_up();
   end
endmodule // testbench
bind gear_scaler gear_scaler_monitor gear_scaler_monitor_i (.CLK(CLK), .RSTN(RSTN),
   .PULSES_PER_ROTATION(PULSES_PER_ROTATION), .TRAVEL_PER_ROTATION(TRAVEL_PER_ROTATION),
   .BACKLASH_AMOUNT(BACKLASH_AMOUNT), .BACKLASH_EXPANDED(BACKLASH_EXPANDED),
   .CMD_VALID(CMD_VALID), .HOME_DONE(HOME_DONE), .CURVAL_CHANGE_DONE(CURVAL_CHANGE_DONE),
   .SPEED_SWITCH_START(SPEED_SWITCH_START), .FEED_VALUE_UPDATE(FEED_VALUE_UPDATE),
   .FIXED_PITCH_START(FIXED_PITCH_START), .CMD_READY(CMD_READY), .CMD_REJECT(CMD_REJECT),
   .PULSE_VALID(PULSE_VALID), .REMAINDER(REMAINDER), .RATIO_INVALID(RATIO_INVALID),
   .BACKLASH_INVALID(BACKLASH_INVALID));
